// [include/swe_defines.svh]
// Constants for the serial word EEPROM access block
`ifndef SWE_DEFINES_SVH
`define SWE_DEFINES_SVH
`define SWE_ADDR_W 8
`define SWE_DATA_W 16
`define SWE_WORDS 256
`define SWE_OPC_W 3
`define SWE_OP_READ 3'h6
`define SWE_OP_WRITE 3'h5
`define SWE_OP_PAGE 3'h7
`define SWE_OP_WRALL 3'h1
`define SWE_OP_PRWR 3'h3
`define SWE_OP_LOCK 3'h2
`define SWE_PAGE_WORDS 3'h4
`define SWE_PAGE_LAST 3'h3
`define SWE_OPC_LAST 4'h2
`define SWE_ADDR_LAST 4'h7
`define SWE_BIT_LAST 4'hF
`define SWE_PTR_LAST 8'hFF
`define SWE_PTR_ONE 8'h01
`define SWE_CLK_HZ 10_000_000
`define SWE_HZ_PER_MHZ 1_000_000
`define SWE_PROG_TIME_US 1000
`endif

// [include/swe_pkg.sv]
// Types shared by the serial word EEPROM access block
`default_nettype none
package swe_pkg;
    typedef struct packed {
        logic sel;
        logic sclk;
        logic din;
        logic supply_low;
    } swe_pins_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC = 3'b001,
        ST_ADDR = 3'b010,
        ST_DIN = 3'b011,
        ST_RDOUT = 3'b100,
        ST_WAIT = 3'b101
    } swe_state_e;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_WORD = 3'b001,
        K_PAGE = 3'b010,
        K_ALL = 3'b011,
        K_PROT = 3'b100,
        K_LOCK = 3'b101
    } swe_kind_e;
endpackage
`default_nettype wire

// [hdl/swe_sync.sv]
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module swe_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Pins
    input wire swe_pkg::swe_pins_s pins_raw,
    output swe_pkg::swe_pins_s pins_filt
);
    import swe_pkg::*;

    logic [3:0] raw_w;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] filt_r;

    assign raw_w = pins_raw;
    assign pins_filt = filt_r;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bit
            // First stage feeds only the second one
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw_w[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        filt_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [hdl/swe_top.sv]
// Serial word EEPROM access logic: command decode, array, programming
`include "swe_defines.svh"
`default_nettype none
// Notes on behaviour
// - Read loads the word at the received address and sets the pointer one past it, then shifts that word out
// - Pointer advances after each word; stream continues while select stays high
// - Pointer wraps from the highest address to zero and reading goes on
// - Array holds 16-bit words, 256 of them, pointer sized to match
// - Page write takes up to four words, stored in one programming cycle
// - Page words go to consecutive addresses, only if none is protected
// - Single write stores all 16 bits of one unprotected word
// - Write-all stores the same pattern into every unprotected word
// - Writes into the protected region set by the protect register are refused
// - Once the lock bit is set the protect register never changes
// - Programming is timed by the core clock, independent of the serial clock
// - Each write overwrites its target; no separate erase is needed
// - After programming starts, select high shows ready/busy on the output
// - Every operation is blocked while the supply is too low
module swe_top #(
    parameter int PROG_TIME_US = `SWE_PROG_TIME_US
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial bus from the master
    input wire logic ee_sel,
    input wire logic ee_sclk,
    input wire logic ee_din,
    // Supply monitor
    input wire logic supply_low,
    // Serial output pin
    output logic ee_dout,
    output logic ee_dout_oe
);
    import swe_pkg::*;

    localparam int PROG_CYCLES =
        PROG_TIME_US * (`SWE_CLK_HZ / `SWE_HZ_PER_MHZ);

    swe_pins_s pins_raw;
    swe_pins_s pf;
    logic sclk_d_r;
    logic sel_d_r;
    logic rise_w;
    logic fall_w;
    logic sel_fall_w;
    logic ok_w;

    swe_state_e st_r;
    logic [3:0] bitcnt_r;
    logic [`SWE_OPC_W-1:0] opc_r;
    logic [`SWE_ADDR_W-1:0] addr_r;
    logic [`SWE_DATA_W-1:0] din_sh_r;
    logic [`SWE_DATA_W-1:0] word_w;
    logic [`SWE_ADDR_W-1:0] addr_full_w;

    logic [`SWE_DATA_W-1:0] mem [`SWE_WORDS];
    logic [`SWE_DATA_W-1:0] page_buf [4];
    logic [2:0] pcnt_r;
    logic prot_hit_r;

    logic [`SWE_ADDR_W-1:0] ptr_r;
    logic [`SWE_DATA_W-1:0] sh_out_r;

    logic prot_en_r;
    logic [`SWE_ADDR_W-1:0] prot_bound_r;
    logic lock_r;

    logic busy_r;
    logic [23:0] timer_r;
    swe_kind_e kind_r;
    swe_kind_e kind_w;
    logic [`SWE_ADDR_W-1:0] idx_r;
    logic [`SWE_ADDR_W-1:0] base_r;
    logic start_w;
    logic walk_w;
    logic last_w;
    logic wr_en_w;
    logic [`SWE_ADDR_W-1:0] waddr_w;
    logic [`SWE_DATA_W-1:0] wdata_w;

    logic stat_r;
    logic dout_r;
    logic dout_oe_r;

    function automatic logic is_prot(input logic [`SWE_ADDR_W-1:0] a);
        return prot_en_r && (a >= prot_bound_r);
    endfunction

    // ***********************************************
    // Pin sampling
    // ***********************************************
    assign pins_raw = '{sel: ee_sel, sclk: ee_sclk, din: ee_din,
                        supply_low: supply_low};

    swe_sync u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pins_raw(pins_raw),
        .pins_filt(pf)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d_r <= 1'b0;
            sel_d_r <= 1'b0;
        end else begin
            sclk_d_r <= pf.sclk;
            sel_d_r <= pf.sel;
        end
    end

    assign rise_w = pf.sclk & ~sclk_d_r;
    assign fall_w = ~pf.sclk & sclk_d_r;
    assign sel_fall_w = ~pf.sel & sel_d_r;
    assign ok_w = ~pf.supply_low;
    assign word_w = {din_sh_r[`SWE_DATA_W-2:0], pf.din};
    assign addr_full_w = {addr_r[`SWE_ADDR_W-2:0], pf.din};

    // ***********************************************
    // Instruction decode
    // ***********************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
            opc_r <= 3'h0;
            addr_r <= 8'h00;
            din_sh_r <= 16'h0000;
        end else if (!ok_w || !pf.sel) begin
            st_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (rise_w && pf.din && !busy_r) begin
                        st_r <= ST_OPC;
                        bitcnt_r <= 4'h0;
                    end
                end
                ST_OPC: begin
                    if (rise_w) begin
                        opc_r <= {opc_r[1:0], pf.din};
                        if (bitcnt_r == `SWE_OPC_LAST) begin
                            st_r <= ST_ADDR;
                            bitcnt_r <= 4'h0;
                        end else begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise_w) begin
                        addr_r <= addr_full_w;
                        if (bitcnt_r == `SWE_ADDR_LAST) begin
                            bitcnt_r <= 4'h0;
                            if (opc_r == `SWE_OP_READ) begin
                                st_r <= ST_RDOUT;
                            end else if (opc_r == `SWE_OP_WRITE ||
                                         opc_r == `SWE_OP_PAGE ||
                                         opc_r == `SWE_OP_WRALL) begin
                                st_r <= ST_DIN;
                            end else begin
                                st_r <= ST_WAIT;
                            end
                        end else begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                    end
                end
                ST_DIN: begin
                    if (rise_w) begin
                        din_sh_r <= word_w;
                        bitcnt_r <= bitcnt_r + 4'h1;
                        if (bitcnt_r == `SWE_BIT_LAST &&
                            (opc_r != `SWE_OP_PAGE ||
                             pcnt_r == `SWE_PAGE_LAST)) begin
                            st_r <= ST_WAIT;
                        end
                    end
                end
                ST_RDOUT: begin
                    if (fall_w) begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                ST_WAIT: begin
                    st_r <= ST_WAIT;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ***********************************************
    // Page buffer
    // ***********************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcnt_r <= 3'h0;
            prot_hit_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                page_buf[i] <= 16'h0000;
            end
        end else if (st_r == ST_IDLE && rise_w && pf.sel && !busy_r) begin
            pcnt_r <= 3'h0;
            prot_hit_r <= 1'b0;
        end else if (st_r == ST_DIN && rise_w && pf.sel && ok_w &&
                     bitcnt_r == `SWE_BIT_LAST &&
                     pcnt_r < `SWE_PAGE_WORDS) begin
            page_buf[pcnt_r[1:0]] <= word_w;
            pcnt_r <= pcnt_r + 3'h1;
            if (is_prot(addr_r + {5'h00, pcnt_r})) begin
                prot_hit_r <= 1'b1;
            end
        end
    end

    // ***********************************************
    // Sequential read
    // ***********************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_r <= 8'h00;
            sh_out_r <= 16'h0000;
        end else if (st_r == ST_ADDR && rise_w && pf.sel && ok_w &&
                     bitcnt_r == `SWE_ADDR_LAST &&
                     opc_r == `SWE_OP_READ) begin
            sh_out_r <= mem[addr_full_w];
            ptr_r <= addr_full_w + `SWE_PTR_ONE;
        end else if (st_r == ST_RDOUT && fall_w && pf.sel) begin
            if (bitcnt_r == `SWE_BIT_LAST) begin
                sh_out_r <= mem[ptr_r];
                ptr_r <= ptr_r + `SWE_PTR_ONE;
            end else begin
                sh_out_r <= {sh_out_r[`SWE_DATA_W-2:0], 1'b0};
            end
        end
    end

    // ***********************************************
    // Programming engine
    // ***********************************************
    always_comb begin
        kind_w = K_NONE;
        case (opc_r)
            `SWE_OP_WRITE: kind_w = prot_hit_r ? K_NONE : K_WORD;
            `SWE_OP_PAGE: kind_w = prot_hit_r ? K_NONE : K_PAGE;
            `SWE_OP_WRALL: kind_w = K_ALL;
            `SWE_OP_PRWR: kind_w = lock_r ? K_NONE : K_PROT;
            `SWE_OP_LOCK: kind_w = lock_r ? K_NONE : K_LOCK;
            default: kind_w = K_NONE;
        endcase
    end

    // A page cut short by select falling still commits what arrived
    assign start_w = sel_fall_w && ok_w && !busy_r && kind_w != K_NONE &&
        (st_r == ST_WAIT ||
         (st_r == ST_DIN && opc_r == `SWE_OP_PAGE && pcnt_r != 3'h0));
    assign walk_w = busy_r && timer_r == 24'h00_0000;
    assign last_w = (kind_r == K_ALL) ? (idx_r == `SWE_PTR_LAST) :
        (kind_r == K_PAGE) ? (idx_r == {5'h00, pcnt_r - 3'h1}) : 1'b1;
    assign waddr_w = (kind_r == K_ALL) ? idx_r : base_r + idx_r;
    assign wdata_w = (kind_r == K_ALL) ? page_buf[0] : page_buf[idx_r[1:0]];
    // Overwrite in place; the erase is implied by the store
    assign wr_en_w = walk_w && !is_prot(waddr_w) &&
        (kind_r == K_WORD || kind_r == K_PAGE || kind_r == K_ALL);

    // Self-timed on core_clk so a stopped serial clock cannot stall it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            timer_r <= 24'h00_0000;
            kind_r <= K_NONE;
            idx_r <= 8'h00;
            base_r <= 8'h00;
        end else if (!ok_w) begin
            busy_r <= 1'b0;
        end else if (start_w) begin
            busy_r <= 1'b1;
            timer_r <= 24'(PROG_CYCLES - 1);
            kind_r <= kind_w;
            idx_r <= 8'h00;
            base_r <= addr_r;
        end else if (busy_r) begin
            if (timer_r != 24'h00_0000) begin
                timer_r <= timer_r - 24'h00_0001;
            end else if (last_w) begin
                busy_r <= 1'b0;
            end else begin
                idx_r <= idx_r + `SWE_PTR_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_en_w) begin
            mem[waddr_w] <= wdata_w;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prot_en_r <= 1'b0;
            prot_bound_r <= 8'h00;
            lock_r <= 1'b0;
        end else if (walk_w && kind_r == K_PROT && !lock_r) begin
            prot_en_r <= 1'b1;
            prot_bound_r <= base_r;
        end else if (walk_w && kind_r == K_LOCK) begin
            lock_r <= 1'b1;
        end
    end

    // ***********************************************
    // Output pin
    // ***********************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_r <= 1'b0;
        end else if (start_w) begin
            stat_r <= 1'b1;
        end else if (sel_fall_w && !busy_r) begin
            stat_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end else if (st_r == ST_RDOUT && pf.sel) begin
            dout_r <= sh_out_r[`SWE_DATA_W-1];
            dout_oe_r <= 1'b1;
        end else if (stat_r && pf.sel && ok_w && st_r == ST_IDLE) begin
            dout_r <= ~busy_r;
            dout_oe_r <= 1'b1;
        end else begin
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end
    end

    assign ee_dout = dout_r;
    assign ee_dout_oe = dout_oe_r;

    // ***********************************************
    // Checks
    // ***********************************************
    sequence word_done_s;
        st_r == ST_RDOUT && fall_w && pf.sel && bitcnt_r == `SWE_BIT_LAST;
    endsequence

    sequence prog_start_s;
        $rose(busy_r);
    endsequence

    rd_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(st_r == ST_RDOUT) |-> sh_out_r == mem[ptr_r - `SWE_PTR_ONE])
        else $error("read word not loaded from address");
    ptr_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        word_done_s |=> ptr_r == $past(ptr_r) + `SWE_PTR_ONE)
        else $error("pointer did not advance");
    ptr_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        word_done_s ##0 (ptr_r == `SWE_PTR_LAST) |=> ptr_r == 8'h00)
        else $error("pointer did not wrap");
    prot_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_en_w || (walk_w && (kind_r == K_WORD || kind_r == K_PAGE))
        |-> !prot_en_r || waddr_w < prot_bound_r)
        else $error("write hit protected area");
    lock_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lock_r |=> $stable(prot_bound_r) && $stable(prot_en_r))
        else $error("protect register changed while locked");
    prog_time_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        prog_start_s |-> busy_r [*8])
        else $error("programming ended too early");
    page_max_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pcnt_r <= `SWE_PAGE_WORDS)
        else $error("page buffer overrun");
    low_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ok_w |=> !busy_r && st_r == ST_IDLE && !wr_en_w)
        else $error("operation while supply low");
    busy_ign_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        busy_r && st_r == ST_IDLE |=> st_r == ST_IDLE)
        else $error("instruction accepted while busy");
    poll_lvl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        stat_r && pf.sel && ok_w && st_r == ST_IDLE
        |=> dout_oe_r && dout_r == !$past(busy_r))
        else $error("ready/busy level wrong");
endmodule
`default_nettype wire

// [sim/swe_master.sv]
// Serial bus master model that frames instructions and polls status
`include "swe_defines.svh"
`default_nettype none
module swe_master (
    // Core clock, used only to bound status polls
    input wire logic core_clk,
    // Serial pins
    output var logic ee_sel,
    output var logic ee_sclk,
    output var logic ee_din,
    input wire logic ee_dout,
    input wire logic ee_dout_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 400;
    localparam int POLL_MAX = 1000;
    logic [15:0] rd_buf [8];

    initial begin
        ee_sel = 1'b0;
        ee_sclk = 1'b0;
        ee_din = 1'b0;
    end

    // One serial period; an undriven output reads as unknown
    task automatic clk_bit(input logic b, output logic q);
        ee_din = b;
        #HALF;
        q = ee_dout_oe ? ee_dout : 1'bx;
        ee_sclk = 1'b1;
        #HALF;
        ee_sclk = 1'b0;
    endtask

    // Odd offset keeps serial edges away from core edges
    task automatic head(input logic [2:0] op, input logic [7:0] a);
        logic q;
        #13;
        ee_sel = 1'b1;
        #HALF;
        clk_bit(1'b1, q);
        for (int i = 2; i >= 0; i--) clk_bit(op[i], q);
        for (int i = 7; i >= 0; i--) clk_bit(a[i], q);
    endtask

    task automatic put_word(input logic [15:0] w);
        logic q;
        for (int i = 15; i >= 0; i--) clk_bit(w[i], q);
    endtask

    // Clock stands low between frames; data line flips once released
    task automatic stop();
        #HALF;
        ee_sel = 1'b0;
        ee_din = ~ee_din;
        // Select must stay low long enough for the pin filter to see it
        #(2 * HALF);
    endtask

    // Select held high keeps the word stream going
    task automatic read(input logic [7:0] a, input int n);
        head(`SWE_OP_READ, a);
        for (int k = 0; k < n; k++) begin
            for (int i = 15; i >= 0; i--) begin
                clk_bit(~ee_din, rd_buf[k][i]);
            end
        end
        stop();
    endtask

    // Select high with no start bit asks for ready or busy
    task automatic poll(output logic first, output int n);
        #13;
        ee_sel = 1'b1;
        ee_din = 1'b0;
        n = 0;
        repeat (8) @(posedge core_clk);
        #5;
        first = ee_dout_oe ? ee_dout : 1'bx;
        while (!(ee_dout_oe === 1'b1 && ee_dout === 1'b1)
               && n < POLL_MAX) begin
            @(posedge core_clk);
            #5;
            n++;
        end
        stop();
    endtask
endmodule
`default_nettype wire

// [sim/swe_top_tb_top.sv]
// Self-checking testbench for the serial word EEPROM access block
`include "swe_defines.svh"
`default_nettype none
module swe_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Short programming time keeps the run small
    localparam int PROG_US = 2;
    localparam int T_LIMIT = 30000;
    localparam logic [15:0] P1 = 16'hA5C3;
    localparam logic [15:0] P2 = 16'h3C5A;
    logic core_clk;
    logic sys_rst;
    logic ee_sel;
    logic ee_sclk;
    logic ee_din;
    logic supply_low;
    logic ee_dout;
    logic ee_dout_oe;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [15:0] exp_q [$];

    swe_top #(.PROG_TIME_US(PROG_US)) swe_top_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ee_sel(ee_sel),
        .ee_sclk(ee_sclk),
        .ee_din(ee_din),
        .supply_low(supply_low),
        .ee_dout(ee_dout),
        .ee_dout_oe(ee_dout_oe)
    );

    swe_master swe_master_i (
        .core_clk(core_clk),
        .ee_sel(ee_sel),
        .ee_sclk(ee_sclk),
        .ee_din(ee_din),
        .ee_dout(ee_dout),
        .ee_dout_oe(ee_dout_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == T_LIMIT) begin
            n_fail++;
            $display("ERROR run time expected done seen still running");
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask

    task automatic frame(input logic [2:0] op, input logic [7:0] a,
                         input logic [15:0] w, input logic has_data);
        swe_master_i.head(op, a);
        if (has_data) begin
            swe_master_i.put_word(w);
        end
        swe_master_i.stop();
    endtask

    task automatic wait_ready(input logic busy_exp);
        logic first;
        int n;
        swe_master_i.poll(first, n);
        if (busy_exp) begin
            check("busy status", 16'h0000, {15'h0000, first});
        end
        check("ready before bound", 16'h0001, {15'h0000, n < 1000});
    endtask

    task automatic read_chk(input logic [7:0] a);
        int n;
        n = exp_q.size();
        swe_master_i.read(a, n);
        for (int k = 0; k < n; k++) begin
            check("read word", exp_q[k], swe_master_i.rd_buf[k]);
        end
        exp_q.delete();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_fill();
        frame(`SWE_OP_WRALL, 8'h00, P1, 1'b1);
        wait_ready(1'b1);
        exp_q = '{P1, P1};
        read_chk(8'h40);
        frame(`SWE_OP_WRALL, 8'h00, P2, 1'b1);
        // Arrives while the fill is still programming, so it is dropped
        frame(`SWE_OP_WRITE, 8'h05, 16'h0F0F, 1'b1);
        wait_ready(1'b0);
        exp_q = '{P2};
        read_chk(8'h05);
    endtask

    task automatic s_wrap();
        frame(`SWE_OP_WRITE, 8'hFF, 16'h1234, 1'b1);
        wait_ready(1'b0);
        frame(`SWE_OP_WRITE, 8'h00, 16'h5678, 1'b1);
        wait_ready(1'b0);
        // Starting one below the top makes the stream cross the wrap point
        exp_q = '{P2, 16'h1234, 16'h5678, P2};
        read_chk(8'hFE);
    endtask

    task automatic s_page();
        swe_master_i.head(`SWE_OP_PAGE, 8'h10);
        for (int k = 0; k < 4; k++) begin
            swe_master_i.put_word(16'h1100 + 16'(k));
        end
        swe_master_i.stop();
        wait_ready(1'b0);
        exp_q = '{P2, 16'h1100, 16'h1101, 16'h1102, 16'h1103, P2};
        read_chk(8'h0F);
    endtask

    task automatic s_supply();
        supply_low = 1'b1;
        frame(`SWE_OP_WRITE, 8'h20, 16'hDEAD, 1'b1);
        tick(1);
        supply_low = 1'b0;
        tick(60);
        exp_q = '{P2};
        read_chk(8'h20);
    endtask

    // Addresses at and above the bound refuse writes
    task automatic s_protect();
        frame(`SWE_OP_PRWR, 8'h80, 16'h0000, 1'b0);
        tick(60);
        frame(`SWE_OP_WRITE, 8'h90, 16'hBEEF, 1'b1);
        tick(60);
        swe_master_i.head(`SWE_OP_PAGE, 8'h7E);
        for (int k = 0; k < 4; k++) begin
            swe_master_i.put_word(16'h2200 + 16'(k));
        end
        swe_master_i.stop();
        tick(60);
        frame(`SWE_OP_WRITE, 8'h7F, 16'h1111, 1'b1);
        wait_ready(1'b0);
        exp_q = '{P2, 16'h1111, P2, P2};
        read_chk(8'h7E);
        exp_q = '{P2};
        read_chk(8'h90);
    endtask

    // A widened bound after locking would free 0x90 if it were taken
    task automatic s_lock();
        frame(`SWE_OP_LOCK, 8'h00, 16'h0000, 1'b0);
        tick(60);
        frame(`SWE_OP_PRWR, 8'hFF, 16'h0000, 1'b0);
        tick(60);
        frame(`SWE_OP_WRITE, 8'h90, 16'hBEEF, 1'b1);
        tick(60);
        exp_q = '{P2};
        read_chk(8'h90);
    endtask

    initial begin
        sys_rst = 1'b1;
        supply_low = 1'b0;
        tick(20);
        sys_rst = 1'b0;
        tick(10);
        s_fill();
        s_wrap();
        s_page();
        s_supply();
        s_protect();
        s_lock();
        test_done();
    end
endmodule
`default_nettype wire
